// [test_watchdog_timer.sv]
// Self-checking testbench for the watchdog timer.
module test_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import wd_pkg::*;
  localparam int LFD = 4;
  logic clk;
  logic sys_rst;
  wd_mode_e mode;
  logic xtal;
  wd_core_evt_s evt;
  wd_reg_req_s req;
  logic [7:0] rdata;
  logic rst_req;
  logic wake_req;
  logic to_n;
  logic pd_n;
  logic irq;
  int errors;
  int n_checks;
  wd_watchdog_timer #(.LF_DIVIDE(LFD)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .watchdog_mode_cfg(mode), .xtal_clock(xtal), .core_evt(evt), .reg_req(req),
    .reg_rdata(rdata), .wd_reset_req(rst_req), .wd_wake_req(wake_req),
    .timeout_status_flag_n(to_n), .powerdown_status_flag_n(pd_n), .irq(irq));
  wd_core_model core_u (.clk(clk), .sys_rst(sys_rst), .xtal_clock(xtal),
    .wd_wake_req(wake_req), .core_evt(evt));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    chk("read data", e, rdata);
  endtask
  // Counts cycles up to the next reset or wake request, 0 if none came.
  task automatic wait_evt(input int lim, input bit must, output int n);
    n = 0;
    for (int i = 1; i <= lim && n == 0; i++)
    begin
      @(negedge clk);
      if (rst_req === 1'b1 || wake_req === 1'b1)
        n = i;
    end
    if (must && n == 0)
    begin
      errors++;
      $display("unexpected wait: expected request, seen none");
      give_verdict();
    end
  endtask
  task automatic near(input int n, input int e);
    chk("timeout cycles", 1, n >= e - 8 && n <= e + 8);
  endtask
  task automatic set_cfg(input logic [1:0] m, input logic x);
    @(posedge clk);
    mode <= wd_mode_e'(m);
    xtal <= x;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    rd(REG_CONTROL, 8'h16);
    wr(REG_CONTROL, 8'hff);
    rd(REG_CONTROL, 8'h3f);
    rd(3'h6, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_modes();
    logic [1:0] md [7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
    logic [7:0] cw [7] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h02, 8'h26, 8'h3e};
    int tk [7] = '{0, 0, 32, 32, 64, 32, 32};
    int n;
    for (int i = 0; i < 7; i++)
    begin
      set_cfg(md[i], 1'b0);
      wr(REG_CONTROL, cw[i]);
      core_u.pulse(3);
      wait_evt(tk[i] * LFD + 40, tk[i] != 0, n);
      if (tk[i] == 0)
        chk("request while disabled", 0, n);
      else
        near(n, tk[i] * LFD);
    end
    $display("test modes done");
  endtask
  task automatic t_kick();
    int n;
    set_cfg(2'h3, 1'b0);
    wr(REG_CONTROL, 8'h00);
    chk("irq masked", 0, irq);
    rd(REG_IRQ_STATUS, 8'h01);
    wr(REG_IRQ_CLEAR, 8'h01);
    rd(REG_IRQ_STATUS, 8'h00);
    wr(REG_IRQ_ENABLE, 8'h01);
    for (int i = 0; i < 6; i++)
    begin
      core_u.pulse(i % 2 == 0 ? 3 : 0);
      wait_evt(100, 1'b0, n);
      chk("request despite clearing", 0, n);
    end
    wait_evt(160, 1'b1, n);
    chk("reset request", 1, rst_req);
    repeat (2) @(negedge clk);
    chk("irq", 1, irq);
    wr(REG_IRQ_CLEAR, 8'h01);
    repeat (2) @(negedge clk);
    chk("irq after clear", 0, irq);
    $display("test kick done");
  endtask
  task automatic t_sleep();
    int n;
    core_u.pulse(3);
    core_u.pulse(2);
    wait_evt(200, 1'b1, n);
    near(n, 32 * LFD);
    chk("wake request", 1, wake_req);
    chk("timeout flag", 0, to_n);
    chk("powerdown flag", 0, pd_n);
    rd(REG_CORE_STATUS, 8'h04);
    rd(REG_IRQ_STATUS, 8'h02);
    rd(REG_IRQ_ENABLE, 8'h01);
    set_cfg(2'h3, 1'b1);
    core_u.pulse(3);
    core_u.pulse(2);
    wait_evt(200, 1'b1, n);
    wait_evt(400, 1'b1, n);
    near(n, 41 + 32 * LFD);
    set_cfg(2'h2, 1'b0);
    core_u.pulse(2);
    wait_evt(300, 1'b0, n);
    chk("request asleep", 0, n);
    core_u.pulse(1);
    wait_evt(200, 1'b1, n);
    near(n, 32 * LFD);
    set_cfg(2'h0, 1'b0);
    $display("test sleep done");
  endtask
  // A second reset in mid-run must bring the control word and flags back.
  task automatic t_reset();
    wr(REG_CONTROL, 8'h3f);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(REG_CONTROL, 8'h16);
    rd(REG_CORE_STATUS, 8'h03);
    rd(REG_IRQ_STATUS, 8'h00);
    $display("test reset done");
  endtask
  initial
  begin
    errors = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    mode = WD_MODE_OFF;
    xtal = 1'b0;
    req = '0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_modes();
    t_kick();
    t_sleep();
    t_reset();
    give_verdict();
  end
endmodule

// [wd_core_model.sv]
// Processor core and oscillator control model that issues the watchdog events.
module wd_core_model #(
  parameter int unsigned OST_CYC = 40
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Watchdog side
  input wire logic xtal_clock,
  input wire logic wd_wake_req,
  output wd_pkg::wd_core_evt_s core_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  import wd_pkg::*;
  // Only the pulse task writes these bits, so they start from a declared zero.
  logic [3:0] pls_ff = 4'h0;
  logic [7:0] ost_ff;
  assign core_evt = {pls_ff, ost_ff != 8'h00};
  // ==========================================================================
  // Start-up timer
  // A crystal clock needs its start-up time after every wake.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ost_ff <= 8'h00;
    else if (xtal_clock && (wd_wake_req || pls_ff[1]))
      ost_ff <= 8'(OST_CYC);
    else if (ost_ff != 8'h00)
      ost_ff <= ost_ff - 8'h01;
  end
  // Bit 3 clear instruction, 2 sleep entry, 1 sleep exit, 0 oscillator fail.
  task automatic pulse(input int b);
    @(posedge clk);
    pls_ff[b] <= 1'b1;
    @(posedge clk);
    pls_ff <= 4'h0;
  endtask
endmodule

// [wd_pkg.sv]
// Constants, types and register map for the watchdog timer.
package wd_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned LF_HZ = 31_000;
  localparam int unsigned LF_DIV = CLK_HZ / LF_HZ;
  localparam int unsigned LF_DIV_W = 12;
  localparam int unsigned PRESC_W = 23;

  // ==========================================================================
  // Register map, word index on the register port
  localparam int unsigned ADDR_W = 3;
  localparam logic [2:0] REG_CONTROL = 3'h0;
  localparam logic [2:0] REG_IRQ_STATUS = 3'h1;
  localparam logic [2:0] REG_IRQ_CLEAR = 3'h2;
  localparam logic [2:0] REG_IRQ_ENABLE = 3'h3;
  localparam logic [2:0] REG_CORE_STATUS = 3'h4;

  // Control register fields
  localparam int unsigned CTL_EN_BIT = 0;
  localparam int unsigned CTL_PS_LSB = 1;
  localparam int unsigned CTL_PS_MSB = 5;
  localparam logic [4:0] PS_RESET = 5'h0b;
  localparam logic [4:0] PS_MAX = 5'h12;
  localparam logic [4:0] PS_MIN_SHIFT = 5'h05;

  // Interrupt status bits
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_RESET_BIT = 0;
  localparam int unsigned IRQ_WAKE_BIT = 1;

  // Core status bits
  localparam int unsigned CS_TO_N_BIT = 0;
  localparam int unsigned CS_PD_N_BIT = 1;
  localparam int unsigned CS_ACTIVE_BIT = 2;
  localparam int unsigned CS_ASLEEP_BIT = 3;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    WD_MODE_OFF = 2'h0,
    WD_MODE_SOFT = 2'h1,
    WD_MODE_NSLEEP = 2'h2,
    WD_MODE_ON = 2'h3
  } wd_mode_e;

  typedef enum logic [2:0] {
    WD_PWR_AWAKE = 3'h1,
    WD_PWR_ASLEEP = 3'h2,
    WD_PWR_OST_HOLD = 3'h4
  } wd_pwr_e;

  // Events from the processor core and the oscillator logic.
  typedef struct packed {
    logic clear_watchdog_instruction;
    logic sleep_enter;
    logic sleep_exit;
    logic osc_fail;
    logic osc_startup_timer;
  } wd_core_evt_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wd_reg_req_s;

endpackage

// [wd_watchdog_timer.sv]
// Watchdog timer: low-frequency tick, prescaler, mode gating, registers and interrupt.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
module wd_watchdog_timer #(
  parameter int unsigned PRESC_BITS = 23,
  parameter int unsigned LF_DIVIDE = 3225
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Configuration word and clock source
  input wire wd_pkg::wd_mode_e watchdog_mode_cfg,
  input wire logic xtal_clock,
  // Core and oscillator events
  input wire wd_pkg::wd_core_evt_s core_evt,
  // Register port
  input wire wd_pkg::wd_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  // Requests and status
  output logic wd_reset_req,
  output logic wd_wake_req,
  output logic timeout_status_flag_n,
  output logic powerdown_status_flag_n,
  output logic irq
);
  import wd_pkg::*;

  // ==========================================================================
  // Elaboration checks
  if (PRESC_BITS != PRESC_W)
  begin : g_bad_presc
    $error("prescaler width must be 23");
  end
  if (LF_DIVIDE < 2 || LF_DIVIDE >= (1 << LF_DIV_W))
  begin : g_bad_div
    $error("low-frequency divider out of range");
  end

  // ==========================================================================
  // Prescale limit: ratio 32 << n, reserved codes fall back to 1:32.
  function automatic logic [PRESC_W-1:0] period_limit(input logic [4:0] ps);
    logic [4:0] shift;
    logic [PRESC_W:0] ratio;
    shift = (ps > PS_MAX) ? PS_MIN_SHIFT : 5'(ps + PS_MIN_SHIFT);
    ratio = (PRESC_W + 1)'(1) << shift;
    return PRESC_W'(ratio - (PRESC_W + 1)'(1));
  endfunction

  // ==========================================================================
  // Low-frequency tick
  logic [LF_DIV_W-1:0] lf_div_ff;
  logic lf_tick_ff;

  // The divider runs from reset and no system clock selection feeds it, so
  // switching the internal oscillator divider cannot disturb the count.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lf_div_ff <= '0;
      lf_tick_ff <= 1'b0;
    end
    else if (lf_div_ff == LF_DIV_W'(LF_DIVIDE - 1))
    begin
      lf_div_ff <= '0;
      lf_tick_ff <= 1'b1;
    end
    else
    begin
      lf_div_ff <= lf_div_ff + LF_DIV_W'(1);
      lf_tick_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Control register
  logic soft_enable_ff;
  logic [4:0] period_select_ff;
  logic wr_ctl;

  assign wr_ctl = reg_req.wr && (reg_req.addr == REG_CONTROL);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      soft_enable_ff <= 1'b0;
      period_select_ff <= PS_RESET;
    end
    else if (wr_ctl)
    begin
      soft_enable_ff <= reg_req.wdata[CTL_EN_BIT];
      period_select_ff <= reg_req.wdata[CTL_PS_MSB:CTL_PS_LSB];
    end
  end

  // ==========================================================================
  // Power state
  wd_pwr_e pwr_ff;
  wd_pwr_e nxt_pwr;
  logic ost_seen_ff;
  logic timeout;
  logic asleep;

  assign asleep = (pwr_ff == WD_PWR_ASLEEP);

  always_comb
  begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      WD_PWR_AWAKE:
      begin
        if (core_evt.sleep_enter)
        begin
          nxt_pwr = WD_PWR_ASLEEP;
        end
      end
      WD_PWR_ASLEEP:
      begin
        if (core_evt.sleep_exit || timeout)
        begin
          nxt_pwr = xtal_clock ? WD_PWR_OST_HOLD : WD_PWR_AWAKE;
        end
      end
      WD_PWR_OST_HOLD:
      begin
        if (ost_seen_ff && !core_evt.osc_startup_timer)
        begin
          nxt_pwr = WD_PWR_AWAKE;
        end
      end
      default:
      begin
        nxt_pwr = WD_PWR_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pwr_ff <= WD_PWR_AWAKE;
    end
    else
    begin
      pwr_ff <= nxt_pwr;
    end
  end

  // Start-up timer must have been seen running before its end releases the hold.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ost_seen_ff <= 1'b0;
    end
    else if (pwr_ff != WD_PWR_OST_HOLD)
    begin
      ost_seen_ff <= 1'b0;
    end
    else if (core_evt.osc_startup_timer)
    begin
      ost_seen_ff <= 1'b1;
    end
  end

  // ==========================================================================
  // Mode gating
  logic active;

  always_comb
  begin
    unique case (watchdog_mode_cfg)
      WD_MODE_ON: active = 1'b1;
      WD_MODE_NSLEEP: active = !asleep;
      WD_MODE_SOFT: active = soft_enable_ff;
      WD_MODE_OFF: active = 1'b0;
    endcase
  end

  // ==========================================================================
  // Prescaler and timeout
  logic [PRESC_W-1:0] presc_ff;
  logic clear_cnt;

  assign clear_cnt = core_evt.clear_watchdog_instruction
    || core_evt.sleep_enter
    || core_evt.sleep_exit
    || core_evt.osc_fail
    || core_evt.osc_startup_timer
    || !active
    || (pwr_ff == WD_PWR_OST_HOLD);

  // A clear instruction in the same tick as the terminal count wins, so the
  // software that kept its promise is never reset.
  assign timeout = lf_tick_ff && !clear_cnt
    && (presc_ff == period_limit(period_select_ff));

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      presc_ff <= '0;
    end
    else if (clear_cnt || timeout)
    begin
      presc_ff <= '0;
    end
    else if (lf_tick_ff)
    begin
      // Lowering the period below the count would otherwise run for 2^23 ticks.
      presc_ff <= (presc_ff > period_limit(period_select_ff)) ? '0
        : presc_ff + PRESC_W'(1);
    end
  end

  // ==========================================================================
  // Request pulses and core status flags
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wd_reset_req <= 1'b0;
      wd_wake_req <= 1'b0;
    end
    else
    begin
      wd_reset_req <= timeout && !asleep;
      wd_wake_req <= timeout && asleep;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      timeout_status_flag_n <= 1'b1;
      powerdown_status_flag_n <= 1'b1;
    end
    else if (timeout)
    begin
      timeout_status_flag_n <= 1'b0;
      powerdown_status_flag_n <= !asleep;
    end
    else if (core_evt.sleep_enter && !asleep)
    begin
      timeout_status_flag_n <= 1'b1;
      powerdown_status_flag_n <= 1'b0;
    end
    else if (core_evt.clear_watchdog_instruction)
    begin
      timeout_status_flag_n <= 1'b1;
      powerdown_status_flag_n <= 1'b1;
    end
  end

  // ==========================================================================
  // Interrupt status, enable and clear
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_en_ff;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  assign irq_set = {wd_wake_req, wd_reset_req};
  assign irq_clr = (reg_req.wr && reg_req.addr == REG_IRQ_CLEAR)
    ? reg_req.wdata[IRQ_W-1:0] : '0;

  // A new event in the cycle of its clear stays set.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_stat_ff <= '0;
    end
    else
    begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_en_ff <= '0;
    end
    else if (reg_req.wr && reg_req.addr == REG_IRQ_ENABLE)
    begin
      irq_en_ff <= reg_req.wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_en_ff);
    end
  end

  // ==========================================================================
  // Register read, data in the cycle after the strobe only
  logic [7:0] nxt_rdata;

  always_comb
  begin
    nxt_rdata = '0;
    unique case (reg_req.addr)
      REG_CONTROL:
      begin
        nxt_rdata[CTL_EN_BIT] = soft_enable_ff;
        nxt_rdata[CTL_PS_MSB:CTL_PS_LSB] = period_select_ff;
      end
      REG_IRQ_STATUS: nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
      REG_IRQ_ENABLE: nxt_rdata[IRQ_W-1:0] = irq_en_ff;
      REG_CORE_STATUS:
      begin
        nxt_rdata[CS_TO_N_BIT] = timeout_status_flag_n;
        nxt_rdata[CS_PD_N_BIT] = powerdown_status_flag_n;
        nxt_rdata[CS_ACTIVE_BIT] = active;
        nxt_rdata[CS_ASLEEP_BIT] = asleep;
      end
      default: nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rdata <= '0;
    end
    else
    begin
      reg_rdata <= reg_req.rd ? nxt_rdata : 8'h00;
    end
  end

endmodule

// [wd_watchdog_timer_props.sv]
// Concurrent checks on the watchdog timer ports.
module wd_watchdog_timer_props #(
  parameter int unsigned LF_DIVIDE = 3225
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Inputs of the block
  input wire wd_pkg::wd_mode_e watchdog_mode_cfg,
  input wire logic xtal_clock,
  input wire wd_pkg::wd_core_evt_s core_evt,
  input wire wd_pkg::wd_reg_req_s reg_req,
  // Outputs of the block
  input wire logic [7:0] reg_rdata,
  input wire logic wd_reset_req,
  input wire logic wd_wake_req,
  input wire logic timeout_status_flag_n,
  input wire logic powerdown_status_flag_n,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import wd_pkg::*;
  // ==========================================================================
  // Helper logic
  // No timeout can come sooner than the shortest period after the last one.
  logic [31:0] gap_ff;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      gap_ff <= '0;
    else if (wd_reset_req || wd_wake_req)
      gap_ff <= '0;
    else if (gap_ff != '1)
      gap_ff <= gap_ff + 32'h1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // Assertions
  AST_RDATA_IDLE: assert property (!reg_req.rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  AST_CTL_TOP: assert property (reg_req.rd && reg_req.addr == REG_CONTROL |=> reg_rdata[7:6] == 2'h0)
    else $error("control bits 7 and 6 not zero");
  AST_OFF_QUIET: assert property (watchdog_mode_cfg == WD_MODE_OFF && $past(watchdog_mode_cfg) == WD_MODE_OFF |-> !wd_reset_req && !wd_wake_req)
    else $error("request while watchdog off");
  AST_CLR_QUIET: assert property (core_evt.clear_watchdog_instruction |=> !wd_reset_req && !wd_wake_req && timeout_status_flag_n && powerdown_status_flag_n)
    else $error("request or flag after clear instruction");
  AST_SLEEP_FLAGS: assert property (core_evt.sleep_enter |=> !powerdown_status_flag_n && timeout_status_flag_n)
    else $error("flags wrong after sleep entry");
  AST_TO_FLAG: assert property (wd_reset_req |-> !timeout_status_flag_n)
    else $error("reset request without timeout flag");
  AST_WAKE_FLAGS: assert property (wd_wake_req |-> !powerdown_status_flag_n && !timeout_status_flag_n)
    else $error("wake request with wrong flags");
  AST_EXCL: assert property (!(wd_reset_req && wd_wake_req))
    else $error("reset and wake requested together");
  AST_RST_ONE: assert property (wd_reset_req |=> !wd_reset_req [*8])
    else $error("reset request longer than one pulse");
  AST_WAKE_ONE: assert property (wd_wake_req |=> !wd_wake_req [*8])
    else $error("wake request longer than one pulse");
  AST_MIN_GAP: assert property ((wd_reset_req || wd_wake_req) |-> gap_ff >= 32'(31 * LF_DIVIDE))
    else $error("timeout sooner than the shortest period");
endmodule

bind wd_watchdog_timer wd_watchdog_timer_props #(.LF_DIVIDE(LF_DIVIDE)) wd_chk_u (
  .clk(clk),
  .sys_rst(sys_rst),
  .watchdog_mode_cfg(watchdog_mode_cfg),
  .xtal_clock(xtal_clock),
  .core_evt(core_evt),
  .reg_req(reg_req),
  .reg_rdata(reg_rdata),
  .wd_reset_req(wd_reset_req),
  .wd_wake_req(wd_wake_req),
  .timeout_status_flag_n(timeout_status_flag_n),
  .powerdown_status_flag_n(powerdown_status_flag_n),
  .irq(irq)
);
